// ===== src/ucf_core_regs.vh
/*
 Register map, field positions, reset values and timing figures of the
 serial clock and frame core. Included by the core, the checker and the bench.
*/
// How it works
// - Normal async: bit rate is pclk / (16 * (divisor + 1)).
// - Double speed async: bit rate is pclk / (8 * (divisor + 1)).
// - Sync or SPI master: serial clock is pclk / (2 * (divisor + 1)).
// - Divider serves async and master; slave uses synchronised external clock.
// - Mode field picks async or sync; double speed bit picks 8x sampling.
// - Master bit drives clock pin from generator; clear takes it as input.
// - Clock pin is active only in sync or SPI modes.
// - Slave clock passes synchroniser and edge detector, two cycles latency.
// - Sync modes sample on one clock edge, change data on the other.
// - Polarity zero: change on rising, sample on falling; one swaps them.
// - All thirty formats: 5-9 data, parity none/even/odd, 1-2 stops.
// - Frame order: start, data LSB first, parity, stop bits.
// - High to low on the data line starts a frame; sync modes start on a low level seen at the sample edge.
// - After a frame, start the next at once or idle the line high.
// - Parity is XOR of data bits, inverted for odd parity.
// - Transmitter and receiver share length and parity; stop select sets transmit only, receiver checks one stop bit.
// - Data write loads transmit buffer; read returns oldest receive entry.
// - SPI master starts clocking when data is written.
// - Data writes ignored when disabled or both enables are clear.
// - One transmit buffer ahead of the shifter gives gapless frames.
// - Two-entry receive FIFO with frame, overrun and parity errors.
// - Mode field: 00 async, 01 sync, 11 SPI, 10 reserved.
// - Length field: 000-011 five to eight bits, 111 nine bits.
// - Parity field: 00 none, 10 even, 11 odd, 01 reserved.
// - Stop select 0 gives one stop bit, 1 gives two.
`ifndef UCF_CORE_REGS_VH
`define UCF_CORE_REGS_VH
// Byte addresses
`define UCF_CTRL1_ADDR   32'h40003800
`define UCF_CTRL2_ADDR   32'h40003804
`define UCF_STAT_ADDR    32'h4000380C
`define UCF_BAUD_ADDR    32'h40003810
`define UCF_DATA_ADDR    32'h40003814
`define UCF_FRAC_ADDR    32'h40003818
`define UCF_RTO_ADDR     32'h4000381C
// Control 1 fields
`define UCF_C1_MODE      15:14
`define UCF_C1_PAR       13:12
`define UCF_C1_LEN       11:9
`define UCF_C1_CPOL      7
`define UCF_C1_TX_ENABLE_BIT      1
`define UCF_C1_RX_ENABLE_BIT      0
// Control 2 fields
`define UCF_C2_EN        9
`define UCF_C2_DBLS      8
`define UCF_C2_MASTER    7
`define UCF_C2_SB        2
`define UCF_C2_TX8       1
`define UCF_C2_RX8       0
// Status fields
`define UCF_ST_DRE       7
`define UCF_ST_TXC       6
`define UCF_ST_RXC       5
`define UCF_ST_DOR       2
`define UCF_ST_FE        1
`define UCF_ST_PE        0
// Reset values
`define UCF_BAUD_RESET   12'hFFF
`define UCF_FRAC_RESET   8'hFF
`define UCF_RTO_RESET    24'h000000
// Oversampling per bit
`define UCF_OS_NORMAL    5'h10
`define UCF_OS_DOUBLE    5'h08
`endif

// ===== src/ucf_core.v
/*
 Serial clock and frame core: divider, slave clock synchroniser,
 transmitter with one buffer, receiver with a two-entry FIFO, APB slave.
 Assumes pins and APB are synchronous to pclk; one clock domain.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ucf_core_regs.vh"

module ucf_core #(
	parameter DIV_W = 12
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg         pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	input  wire        rx_data_pin,
	input  wire        serial_clock_pin_in,
	output reg         tx_data_pin,
	output reg         serial_clock_pin_out,
	output reg         serial_clock_pin_oe
);

	// Sync and SPI codes decode as synchronous clocking
	function ucf_is_sync;
		input [1:0] m;
		begin
			ucf_is_sync = (m == 2'b01) || (m == 2'b11);
		end
	endfunction

	// Data length decode, reserved codes fall back to eight bits
	function [3:0] ucf_dlen;
		input [2:0] c;
		begin
			if (c == 3'b111)
				ucf_dlen = 4'h9;
			else if (c[2] == 1'b0)
				ucf_dlen = {2'b01, c[1:0]} + 4'h1;
			else
				ucf_dlen = 4'h8;
		end
	endfunction

	// Parity over the low n data bits, seeded for odd parity
	function ucf_par;
		input [8:0] d;
		input [3:0] n;
		input       odd;
		integer i;
		begin
			ucf_par = odd;
			for (i = 0; i < 9; i = i + 1)
				if (i < n)
					ucf_par = ucf_par ^ d[i];
		end
	endfunction

	// Frame image, bit 0 first; unused tail stays high as stop bits
	function [12:0] ucf_frame;
		input [8:0] d;
		input [3:0] n;
		input       pe;
		input       odd;
		integer i;
		begin
			ucf_frame = 13'h1FFF;
			ucf_frame[0] = 1'b0;
			for (i = 0; i < 9; i = i + 1)
				if (i < n)
					ucf_frame[i + 1] = d[i];
			if (pe)
				ucf_frame[n + 4'h1] = ucf_par(d, n, odd);
		end
	endfunction

	// Received data bits out of the sample image
	function [8:0] ucf_rdata;
		input [12:0] s;
		input [3:0]  n;
		integer i;
		begin
			ucf_rdata = 9'h000;
			for (i = 0; i < 9; i = i + 1)
				if (i < n)
					ucf_rdata[i] = s[i + 1];
		end
	endfunction

	reg [1:0]       c1_mode;
	reg [1:0]       c1_par;
	reg [2:0]       c1_len;
	reg             c1_cpol;
	reg             c1_tx_enable_bit;
	reg             c1_rx_enable_bit;
	reg             c2_en;
	reg             c2_dbls;
	reg             c2_master;
	reg             c2_sb;
	reg             c2_tx8;
	reg [DIV_W-1:0] divisor_value;
	reg [7:0]       frac_cnt;
	reg [23:0]      rto_val;
	reg [DIV_W-1:0] bcnt;
	reg             sck_s1;
	reg             sck_s2;
	reg             sck_s3;
	reg [8:0]       tbuf;
	reg             tbuf_v;
	reg             tx_busy;
	reg [12:0]      tsh;
	reg [3:0]       tleft;
	reg [4:0]       tos;
	reg             txc;
	reg             rx_busy;
	reg             rx_prev;
	reg             rx_push;
	reg [3:0]       rn;
	reg [12:0]      rsh;
	reg [4:0]       ros;
	reg [10:0]      rxq [0:1];
	reg [1:0]       fcnt;
	reg             dor;
	reg [31:0]      rmux;
	reg             hit;

	// Shared format decode for both directions
	wire       sync_m = ucf_is_sync(c1_mode);
	wire [3:0] dlen   = ucf_dlen(c1_len);
	wire       par_en = c1_par[1];
	wire       odd    = c1_par[1] & c1_par[0];
	wire [3:0] flen   = 4'h1 + dlen + {3'b000, par_en} + (c2_sb ? 4'h2 : 4'h1);
	wire [3:0] rlen   = 4'h2 + dlen + {3'b000, par_en};
	wire [4:0] os_top = (c2_dbls ? `UCF_OS_DOUBLE : `UCF_OS_NORMAL) - 5'h01;
	wire [4:0] os_mid = {1'b0, os_top[4:1]};

	// APB qualifiers
	wire acc   = psel & penable & pready;
	wire wr    = acc & pwrite;
	wire rd    = acc & ~pwrite;
	wire dr_wr = wr & (paddr == `UCF_DATA_ADDR) & c2_en & (c1_tx_enable_bit | c1_rx_enable_bit);
	wire rx_on = c2_en & c1_rx_enable_bit;
	wire pop   = rd & (paddr == `UCF_DATA_ADDR) & (fcnt != 2'b00);

	// Divider tick and clock edge events
	wire tick    = c2_en & (bcnt == {DIV_W{1'b0}});
	wire sck_run = c2_en & sync_m & c2_master & (tx_busy | (serial_clock_pin_out != c1_cpol));
	wire m_rise  = tick & sck_run & ~serial_clock_pin_out;
	wire m_fall  = tick & sck_run & serial_clock_pin_out;
	wire s_rise  = sck_s2 & ~sck_s3;
	wire s_fall  = ~sck_s2 & sck_s3;
	wire rise_ev = c2_en & sync_m & (c2_master ? m_rise : s_rise);
	wire fall_ev = c2_en & sync_m & (c2_master ? m_fall : s_fall);
	wire chg_ev  = c1_cpol ? fall_ev : rise_ev;
	wire smp_ev  = c1_cpol ? rise_ev : fall_ev;

	// Bit boundaries for each direction
	wire tx_end  = sync_m ? chg_ev : (tick & (tos == os_top));
	wire rs_ev   = sync_m ? smp_ev : (tick & (ros == os_mid));
	wire rx_last = rx_busy & rs_ev & (rn == rlen - 4'h1);

	wire [12:0] tfr   = ucf_frame(tbuf, dlen, par_en, odd);
	wire [8:0]  rdat  = ucf_rdata(rsh, dlen);
	wire        rfe   = ~rsh[rlen - 4'h1];
	wire        rpe   = par_en & (ucf_par(rdat, dlen, odd) != rsh[dlen + 4'h1]);
	wire [10:0] rhead = (fcnt != 2'b00) ? rxq[0] : 11'h000;

	// Register read mux
	always @*
	begin
		rmux = 32'h00000000;
		hit = 1'b1;
		case (paddr)
			`UCF_CTRL1_ADDR:
			begin
				rmux[`UCF_C1_MODE] = c1_mode;
				rmux[`UCF_C1_PAR] = c1_par;
				rmux[`UCF_C1_LEN] = c1_len;
				rmux[`UCF_C1_CPOL] = c1_cpol;
				rmux[`UCF_C1_TX_ENABLE_BIT] = c1_tx_enable_bit;
				rmux[`UCF_C1_RX_ENABLE_BIT] = c1_rx_enable_bit;
			end
			`UCF_CTRL2_ADDR:
			begin
				rmux[`UCF_C2_EN] = c2_en;
				rmux[`UCF_C2_DBLS] = c2_dbls;
				rmux[`UCF_C2_MASTER] = c2_master;
				rmux[`UCF_C2_SB] = c2_sb;
				rmux[`UCF_C2_TX8] = c2_tx8;
				rmux[`UCF_C2_RX8] = rhead[8];
			end
			`UCF_STAT_ADDR:
			begin
				rmux[`UCF_ST_DRE] = ~tbuf_v;
				rmux[`UCF_ST_TXC] = txc;
				rmux[`UCF_ST_RXC] = (fcnt != 2'b00);
				rmux[`UCF_ST_DOR] = dor;
				rmux[`UCF_ST_FE] = rhead[9];
				rmux[`UCF_ST_PE] = rhead[10];
			end
			`UCF_BAUD_ADDR:
				rmux[DIV_W-1:0] = divisor_value;
			`UCF_DATA_ADDR:
				rmux[7:0] = rhead[7:0];
			`UCF_FRAC_ADDR:
				rmux[7:0] = frac_cnt;
			`UCF_RTO_ADDR:
				rmux[23:0] = rto_val;
			default:
				hit = 1'b0;
		endcase
	end

	// APB answer one cycle into the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel & penable & ~pready)
		begin
			pready <= 1'b1;
			prdata <= rmux;
			pslverr <= ~hit;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			c1_mode <= 2'b00;
			c1_par <= 2'b00;
			c1_len <= 3'b000;
			c1_cpol <= 1'b0;
			c1_tx_enable_bit <= 1'b0;
			c1_rx_enable_bit <= 1'b0;
			c2_en <= 1'b0;
			c2_dbls <= 1'b0;
			c2_master <= 1'b0;
			c2_sb <= 1'b0;
			c2_tx8 <= 1'b0;
			divisor_value <= `UCF_BAUD_RESET;
			frac_cnt <= `UCF_FRAC_RESET;
			rto_val <= `UCF_RTO_RESET;
		end
		else if (wr)
		begin
			case (paddr)
				`UCF_CTRL1_ADDR:
				begin
					c1_mode <= pwdata[`UCF_C1_MODE];
					c1_par <= pwdata[`UCF_C1_PAR];
					c1_len <= pwdata[`UCF_C1_LEN];
					c1_cpol <= pwdata[`UCF_C1_CPOL];
					c1_tx_enable_bit <= pwdata[`UCF_C1_TX_ENABLE_BIT];
					c1_rx_enable_bit <= pwdata[`UCF_C1_RX_ENABLE_BIT];
				end
				`UCF_CTRL2_ADDR:
				begin
					c2_en <= pwdata[`UCF_C2_EN];
					c2_dbls <= pwdata[`UCF_C2_DBLS];
					c2_master <= pwdata[`UCF_C2_MASTER];
					c2_sb <= pwdata[`UCF_C2_SB];
					c2_tx8 <= pwdata[`UCF_C2_TX8];
				end
				`UCF_BAUD_ADDR:
					divisor_value <= pwdata[DIV_W-1:0];
				`UCF_FRAC_ADDR:
					frac_cnt <= pwdata[7:0];
				`UCF_RTO_ADDR:
					rto_val <= pwdata[23:0];
				default:
					c2_en <= c2_en;
			endcase
		end
	end

	// Reloading divider and master serial clock
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bcnt <= `UCF_BAUD_RESET;
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
		end
		else
		begin
			if (!c2_en || tick)
				bcnt <= divisor_value;
			else
				bcnt <= bcnt - {{(DIV_W-1){1'b0}}, 1'b1};
			if (tick & sck_run)
				serial_clock_pin_out <= ~serial_clock_pin_out;
			serial_clock_pin_oe <= c2_en & sync_m & c2_master;
		end
	end

	// External clock synchroniser, first stage feeds only the second
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
		end
		else
		begin
			sck_s1 <= serial_clock_pin_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
		end
	end

	// Transmit buffer, shifter and completion flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tbuf <= 9'h000;
			tbuf_v <= 1'b0;
			tx_busy <= 1'b0;
			tsh <= 13'h1FFF;
			tleft <= 4'h0;
			tos <= 5'h00;
			txc <= 1'b0;
			tx_data_pin <= 1'b1;
		end
		else
		begin
			if (wr && paddr == `UCF_STAT_ADDR && pwdata[`UCF_ST_TXC])
				txc <= 1'b0;
			if (!c2_en)
			begin
				tx_busy <= 1'b0;
				tx_data_pin <= 1'b1;
			end
			else if (!tx_busy)
			begin
				tos <= 5'h00;
				// Async frames start on a tick so the start bit is a full bit
				if (tbuf_v & c1_tx_enable_bit & (sync_m | tick))
				begin
					tx_busy <= 1'b1;
					tbuf_v <= 1'b0;
					if (sync_m)
					begin
						tsh <= tfr;
						tleft <= flen;
					end
					else
					begin
						tx_data_pin <= tfr[0];
						tsh <= {1'b1, tfr[12:1]};
						tleft <= flen - 4'h1;
					end
				end
			end
			else
			begin
				if (tick)
					tos <= (tos == os_top) ? 5'h00 : tos + 5'h01;
				if (tx_end)
				begin
					if (tleft != 4'h0)
					begin
						tx_data_pin <= tsh[0];
						tsh <= {1'b1, tsh[12:1]};
						tleft <= tleft - 4'h1;
					end
					else if (tbuf_v & c1_tx_enable_bit)
					begin
						tbuf_v <= 1'b0;
						tx_data_pin <= tfr[0];
						tsh <= {1'b1, tfr[12:1]};
						tleft <= flen - 4'h1;
					end
					else
					begin
						tx_busy <= 1'b0;
						tx_data_pin <= 1'b1;
						txc <= 1'b1;
					end
				end
			end
			if (dr_wr)
			begin
				tbuf <= {c2_tx8, pwdata[7:0]};
				tbuf_v <= 1'b1;
			end
		end
	end

	// Receive shifter, async by oversampling, sync by sample edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_busy <= 1'b0;
			rx_prev <= 1'b1;
			rx_push <= 1'b0;
			rn <= 4'h0;
			rsh <= 13'h0000;
			ros <= 5'h00;
		end
		else
		begin
			rx_prev <= rx_data_pin;
			rx_push <= rx_last;
			if (!rx_on)
				rx_busy <= 1'b0;
			else if (!rx_busy)
			begin
				ros <= 5'h00;
				rn <= 4'h0;
				if (sync_m & smp_ev & ~rx_data_pin)
				begin
					rx_busy <= 1'b1;
					rsh[0] <= 1'b0;
					rn <= 4'h1;
				end
				else if (~sync_m & rx_prev & ~rx_data_pin)
					rx_busy <= 1'b1;
			end
			else
			begin
				if (tick)
					ros <= (ros == os_top) ? 5'h00 : ros + 5'h01;
				if (rs_ev)
				begin
					if (rn == 4'h0 && rx_data_pin)
						rx_busy <= 1'b0;
					else
					begin
						rsh[rn] <= rx_data_pin;
						rn <= rn + 4'h1;
						if (rx_last)
							rx_busy <= 1'b0;
					end
				end
			end
		end
	end

	// Two-entry receive FIFO with error bits and overrun
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rxq[0] <= 11'h000;
			rxq[1] <= 11'h000;
			fcnt <= 2'b00;
			dor <= 1'b0;
		end
		else if (!rx_on)
		begin
			fcnt <= 2'b00;
			dor <= 1'b0;
		end
		else
		begin
			if (pop)
			begin
				rxq[0] <= rxq[1];
				dor <= 1'b0;
			end
			if (rx_push)
			begin
				if (fcnt == 2'b10 && !pop)
					dor <= 1'b1;
				else if (fcnt == 2'b00 || (fcnt == 2'b01 && pop))
					rxq[0] <= {rpe, rfe, rdat};
				else
					rxq[1] <= {rpe, rfe, rdat};
			end
			if (pop && !rx_push)
				fcnt <= fcnt - 2'b01;
			else if (rx_push && !pop && fcnt != 2'b10)
				fcnt <= fcnt + 2'b01;
		end
	end

endmodule // ucf_core
`default_nettype wire

// ===== verif/ucf_core_asserts.sv
/*
 Port checker for the serial clock and frame core.
 Assumes it is bound onto ucf_core; one clock, pclk, reset presetn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucf_core_regs.vh"
module ucf_core_asserts #(
	parameter DIV_W = 12
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        tx_data_pin,
	input wire logic        serial_clock_pin_out,
	input wire logic        serial_clock_pin_oe
);
	logic [1:0]       mode;
	logic             en;
	logic             dbl;
	logic             mst;
	logic [DIV_W-1:0] div;
	logic [15:0]      lo_n;
	logic [15:0]      hi_n;
	int               per;
	wire              wr = psel && penable && pready && pwrite;

	// Expected bit length in pclk cycles
	assign per = (dbl ? 8 : 16) * (div + 1);

	// Shadow of the settings, taken at completed writes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mode <= 2'h0;
			en   <= 1'b0;
			dbl  <= 1'b0;
			mst  <= 1'b0;
			div  <= '1;
		end
		else if (wr && paddr == `UCF_CTRL1_ADDR)
			mode <= pwdata[`UCF_C1_MODE];
		else if (wr && paddr == `UCF_BAUD_ADDR)
			div <= pwdata[DIV_W-1:0];
		else if (wr && paddr == `UCF_CTRL2_ADDR)
		begin
			en  <= pwdata[`UCF_C2_EN];
			dbl <= pwdata[`UCF_C2_DBLS];
			mst <= pwdata[`UCF_C2_MASTER];
		end

	// Run lengths of low data and high serial clock
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lo_n <= 16'h0000;
			hi_n <= 16'h0000;
		end
		else
		begin
			lo_n <= tx_data_pin ? 16'h0000 : lo_n + 16'h0001;
			hi_n <= serial_clock_pin_out ? hi_n + 16'h0001 : 16'h0000;
		end

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_READY_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error response without ready");
	AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready)
		else $error("read data moved outside an answer");
	AST_ASYNC_NO_CLK: assert property ((!mode[0]) [*3] |-> !serial_clock_pin_oe)
		else $error("clock pin driven in async mode");
	AST_SLAVE_NO_CLK: assert property ((!mst) [*3] |-> !serial_clock_pin_oe)
		else $error("clock pin driven as slave");
	AST_MASTER_CLK: assert property ((en && mst && mode[0]) [*3] |-> serial_clock_pin_oe)
		else $error("clock pin not driven as master");
	AST_BIT_LEN: assert property ($rose(tx_data_pin) && !mode[0] |-> lo_n != 0 && lo_n % per == 0)
		else $error("async bit length wrong");
	AST_SCK_HALF: assert property ($fell(serial_clock_pin_out) && serial_clock_pin_oe |-> hi_n == div + 1)
		else $error("serial clock half period wrong");
endmodule // ucf_core_asserts

bind ucf_core ucf_core_asserts #(.DIV_W(DIV_W)) ucf_core_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .tx_data_pin(tx_data_pin),
	.serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe(serial_clock_pin_oe)
);
`default_nettype wire

// ===== verif/ucf_far_end.sv
/*
 Remote async transmitter model feeding the core's serial data input.
 Assumes pclk from the bench; its serial clock moves only while pulsed.
*/
`timescale 1ns/1ps
`default_nettype none
module ucf_far_end (
	input  wire logic pclk,
	output var  logic rx_data_pin,
	output var  logic serial_clock_pin_in
);
	// Line idles high, clock still
	initial
	begin
		rx_data_pin = 1'b1;
		serial_clock_pin_in = 1'b0;
	end

	// One frame; pm 0 none, 1 even, 2 odd
	task automatic send(input logic [8:0] d, input int nb, pm, sb, per);
		logic [12:0] f;
		int          n;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < nb; i++)
			f[i+1] = d[i];
		n = nb + 1;
		if (pm != 0)
		begin
			f[n] = ^(d & ((9'h001 << nb) - 9'h001)) ^ (pm == 2);
			n++;
		end
		n += sb;
		@(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			rx_data_pin <= f[i];
			repeat (per) @(posedge pclk);
		end
	endtask

	// One slave clock pulse, high for hp cycles, then low again
	task automatic pulse(input int hp);
		@(posedge pclk);
		serial_clock_pin_in <= 1'b1;
		repeat (hp) @(posedge pclk);
		serial_clock_pin_in <= 1'b0;
		repeat (hp - 1) @(posedge pclk);
	endtask
endmodule // ucf_far_end
`default_nettype wire

// ===== verif/test_usart_clock_and_frame_core.sv
/*
 Self-checking bench for the serial clock and frame core.
 Assumes the checker is bound to the core and the far end model drives its input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucf_core_regs.vh"
module test_usart_clock_and_frame_core;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] rd;
	logic        se;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         rxd;
	wire         sck_in;
	wire         txd;
	wire         sck_out;
	wire         sck_oe;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          n;
	logic [31:0] c1 [3] = '{32'h2603, 32'h3003, 32'h0E03};
	logic [31:0] c2 [3] = '{32'h0204, 32'h0300, 32'h0202};
	logic [11:0] bd [3] = '{12'h000, 12'h001, 12'h000};
	logic [8:0]  dv [3] = '{9'h0A5, 9'h016, 9'h1AB};
	int          nb [3] = '{8, 5, 9};
	int          pm [3] = '{1, 2, 0};
	int          sb [3] = '{2, 1, 1};

	ucf_core ucf_core_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rx_data_pin(rxd),
		.serial_clock_pin_in(sck_in), .tx_data_pin(txd),
		.serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe)
	);
	ucf_far_end ucf_far_end_inst (.pclk(pclk), .rx_data_pin(rxd), .serial_clock_pin_in(sck_in));

	// Clock at 10 MHz
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, exp, input string nm);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer, held until ready
	task automatic acc(input logic w, input logic [31:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [31:0] a, m, e, input string nm);
		acc(1'b0, a, 32'h0);
		chk(rd & m, e, nm);
	endtask

	// Poll a status bit until set
	task automatic wst(input int b);
		do
			acc(1'b0, `UCF_STAT_ADDR, 32'h0);
		while (rd[b] !== 1'b1);
	endtask

	// Checks one sent frame at mid-bit points
	task automatic txf(input logic [8:0] d, input int nbit, p, s, per, b2b);
		logic [12:0] f;
		int          k;
		int          w;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < nbit; i++)
			f[i+1] = d[i];
		k = nbit + 1;
		if (p != 0)
		begin
			f[k] = ^(d & ((9'h001 << nbit) - 9'h001)) ^ (p == 2);
			k++;
		end
		k += s;
		w = 0;
		while (txd !== 1'b0)
		begin
			@(posedge pclk);
			w++;
		end
		if (b2b)
			chk(w <= per / 2 + 1, 1, "gap");
		repeat (per / 2) @(posedge pclk);
		for (int i = 0; i < k; i++)
		begin
			chk(txd, f[i], "txbit");
			if (i < k - 1)
				repeat (per) @(posedge pclk);
		end
	endtask

	// Main sequence
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`UCF_BAUD_ADDR, 32'hFFF, 32'hFFF, "baud");
		rchk(`UCF_FRAC_ADDR, 32'hFF, 32'hFF, "frac");
		rchk(`UCF_RTO_ADDR, 32'hFFFFFF, 32'h0, "rto");
		rchk(`UCF_STAT_ADDR, 32'h80, 32'h80, "dre");
		rchk(32'h40003808, 32'hFFFFFFFF, 32'h0, "hole");
		chk(se, 1, "slverr");
		$display("test regs done");
		for (int i = 0; i < 3; i++)
		begin
			acc(1'b1, `UCF_BAUD_ADDR, {20'h0, bd[i]});
			rchk(`UCF_BAUD_ADDR, 32'hFFF, {20'h0, bd[i]}, "baudrw");
			acc(1'b1, `UCF_CTRL2_ADDR, c2[i]);
			acc(1'b1, `UCF_CTRL1_ADDR, c1[i]);
			acc(1'b1, `UCF_DATA_ADDR, {24'h0, dv[i][7:0]});
			n = (i == 1 ? 8 : 16) * (bd[i] + 1);
			// Watch the first frame from its start while the second is queued
			fork
				txf(dv[i], nb[i], pm[i], sb[i], n, 0);
				begin
					wst(`UCF_ST_DRE);
					acc(1'b1, `UCF_DATA_ADDR, {24'h0, dv[i][7:0]});
				end
			join
			chk(sck_oe, 0, "oe_async");
			txf(dv[i], nb[i], pm[i], sb[i], n, 1);
		end
		$display("test tx formats done");
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0204);
		acc(1'b1, `UCF_CTRL1_ADDR, 32'h2603);
		ucf_far_end_inst.send(9'h05A, 8, 1, 2, 16);
		ucf_far_end_inst.send(9'h0C3, 8, 2, 2, 16);
		rchk(`UCF_STAT_ADDR, 32'h21, 32'h20, "rxhead");
		rchk(`UCF_DATA_ADDR, 32'hFF, 32'h5A, "rx1");
		rchk(`UCF_STAT_ADDR, 32'h21, 32'h21, "rxpe");
		rchk(`UCF_DATA_ADDR, 32'hFF, 32'hC3, "rx2");
		rchk(`UCF_STAT_ADDR, 32'h20, 32'h0, "rxempty");
		$display("test rx done");
		// Clear tx complete so the poll below waits for this frame
		acc(1'b1, `UCF_STAT_ADDR, 32'h40);
		acc(1'b1, `UCF_BAUD_ADDR, 32'h2);
		acc(1'b1, `UCF_CTRL1_ADDR, 32'h4603);
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0280);
		acc(1'b1, `UCF_DATA_ADDR, 32'h5A);
		while (sck_out !== 1'b1) @(posedge pclk);
		n = 0;
		while (sck_out !== 1'b0)
		begin
			@(posedge pclk);
			n++;
		end
		while (sck_out !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		chk(n, 6, "sckper");
		chk(sck_oe, 1, "oe_master");
		wst(`UCF_ST_TXC);
		chk(txd, 1, "idle");
		$display("test sync master done");
		// SPI slave: far end clocks, one bit per rising edge after sync delay
		acc(1'b1, `UCF_STAT_ADDR, 32'h40);
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0200);
		acc(1'b1, `UCF_CTRL1_ADDR, 32'hC603);
		acc(1'b1, `UCF_DATA_ADDR, 32'hA5);
		chk(sck_oe, 0, "oe_slave");
		for (int i = 0; i < 11; i++)
		begin
			ucf_far_end_inst.pulse(8);
			if (i < 10)
				chk(txd, (10'h34A >> i) & 10'h001, "slavebit");
		end
		rchk(`UCF_STAT_ADDR, 32'h40, 32'h40, "txc_slave");
		$display("test sync slave done");
		acc(1'b1, `UCF_CTRL1_ADDR, 32'h0600);
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0200);
		acc(1'b1, `UCF_DATA_ADDR, 32'h55);
		acc(1'b1, `UCF_CTRL1_ADDR, 32'h0602);
		// Block disabled with tx enabled: the write must be dropped too
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0000);
		acc(1'b1, `UCF_DATA_ADDR, 32'h66);
		acc(1'b1, `UCF_CTRL2_ADDR, 32'h0200);
		repeat (40) @(posedge pclk);
		chk(txd, 1, "ignored");
		rchk(`UCF_STAT_ADDR, 32'h80, 32'h80, "dre_kept");
		$display("test disabled write done");
		summarize();
	end
endmodule // test_usart_clock_and_frame_core
`default_nettype wire
